//--- rtl/port_io_map.vh
// Register map, field limits and reset values of the port register block.
// Assumes byte addressing on a 32-bit bus, one register per aligned word.
//
// Behaviour
// - Port B direction register: 16-bit read/write, one bit per pin, ten pins.
// - Direction bit n controls port B pin n, bit 9 down to bit 0.
// - Direction bit acts only while its pin is in general input/output use.
// - Port A to E data registers reset only by external power-on reset.
// - Data registers keep contents through watchdog reset, standby and sleep.
// - Port F pin state register: 8-bit read-only, bit n is pin n.
// - Writes to port F pin state are discarded; pins are unaffected.
// - Reading port F returns the sampled level of each pin.
// - A port F pin being sampled by the converter reads as 1.
// - Port F pin state has no reset value and always follows pins.
`ifndef PORT_IO_MAP_VH
`define PORT_IO_MAP_VH

// Byte offsets inside the block's window
`define PIO_PA_DATA_OFS   8'h00
`define PIO_PB_DATA_OFS   8'h04
`define PIO_PC_DATA_OFS   8'h08
`define PIO_PD_DATA_OFS   8'h0c
`define PIO_PE_DATA_OFS   8'h10
`define PIO_PB_DIR_OFS    8'h14
`define PIO_PF_STATE_OFS  8'h18

// Decoded part of the address
`define PIO_ADDR_MSB      7

// Reset values
`define PIO_DATA_RST      16'h0000
`define PIO_DIR_RST       16'h0000

// Register widths
`define PIO_DATA_W        16
`define PIO_DIR_W         16
`define PIO_PF_W          8

// Bus encodings
`define PIO_HTRANS_NONSEQ 2'h2
`define PIO_HTRANS_SEQ    2'h3
`define PIO_HSIZE_BYTE    3'h0
`define PIO_HSIZE_HALF    3'h1
`define PIO_HRESP_OKAY    1'b0

`endif

//--- rtl/port_io_regs.v
// Port data and direction registers with an AHB-Lite slave.
// Assumes the bus, the pin-function selection, the watchdog reset pulse and
// the converter sampling flags all run on CORE_CLK; pins are asynchronous.
//
// The AHB-Lite register port and the register offsets were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "port_io_map.vh"

module port_io_regs #(
   parameter PB_PINS = 10
) (
   input  wire                 CORE_CLK,
   input  wire                 RST_B,
   input  wire                 WATCHDOG_RST,
   input  wire                 HSEL,
   input  wire [31:0]          HADDR,
   input  wire [1:0]           HTRANS,
   input  wire                 HWRITE,
   input  wire [2:0]           HSIZE,
   input  wire [31:0]          HWDATA,
   input  wire                 HREADY,
   output reg                  HREADYOUT,
   output reg  [31:0]          HRDATA,
   output reg                  HRESP,
   input  wire [PB_PINS-1:0]   PB_FUNC_GPIO,
   input  wire [PB_PINS-1:0]   PB_PIN_IN,
   output reg  [PB_PINS-1:0]   PB_PIN_OUT,
   output reg  [PB_PINS-1:0]   PB_PIN_OE,
   output reg  [15:0]          PA_DATA,
   output reg  [15:0]          PC_DATA,
   output reg  [15:0]          PD_DATA,
   output reg  [15:0]          PE_DATA,
   input  wire [7:0]           PF_PIN_IN,
   input  wire [7:0]           ADC_SAMPLING
);

   // Byte lanes touched by an access of a given size at a given address
   function [3:0] lanes;
      input [2:0] size;
      input [1:0] low;
      begin
         case (size)
            `PIO_HSIZE_BYTE: begin
               lanes = 4'h1 << low;
            end
            `PIO_HSIZE_HALF: begin
               lanes = low[1] ? 4'hc : 4'h3;
            end
            default: begin
               lanes = 4'hf;
            end
         endcase
      end
   endfunction

   // Replaces the enabled bytes of a 16-bit register
   function [15:0] merge16;
      input [15:0] old;
      input [31:0] wd;
      input [3:0]  be;
      begin
         merge16[7:0]  = be[0] ? wd[7:0]  : old[7:0];
         merge16[15:8] = be[1] ? wd[15:8] : old[15:8];
      end
   endfunction

   // Zero-extends a 16-bit value to the bus width
   function [31:0] widen16;
      input [15:0] v;
      begin
         widen16 = {16'h0000, v};
      end
   endfunction

   // Storage
   reg  [15:0]        port_a_low_data_reg;
   reg  [PB_PINS-1:0] port_b_data_reg;
   reg  [15:0]        port_c_data_reg;
   reg  [15:0]        port_d_low_data_reg;
   reg  [15:0]        port_e_data_reg;
   reg  [PB_PINS-1:0] port_b_direction_reg;

   // Pin synchronisers
   reg  [PB_PINS-1:0] pb_meta;
   reg  [PB_PINS-1:0] pb_sync;
   reg  [7:0]         pf_meta;
   reg  [7:0]         pf_sync;

   // Bus write held from address phase to data phase
   reg                wr_pend;
   reg  [`PIO_ADDR_MSB:0] wr_addr;
   reg  [3:0]         wr_be;

   // Next values
   reg  [15:0]        next_a;
   reg  [15:0]        next_b16;
   reg  [PB_PINS-1:0] next_b;
   reg  [15:0]        next_c;
   reg  [15:0]        next_d;
   reg  [15:0]        next_e;
   reg  [15:0]        next_dir16;
   reg  [PB_PINS-1:0] next_dir;
   reg  [31:0]        next_rdata;
   reg  [PB_PINS-1:0] pb_view;
   reg  [15:0]        pb_view16;
   reg  [15:0]        pb_data16;
   reg  [15:0]        pb_dir16;

   wire               addr_phase;
   wire [PB_PINS-1:0] out_active;
   wire [7:0]         pf_view;

   assign addr_phase = HSEL & HREADY & HTRANS[1];

   // Output only where the pin is general-purpose and set to output
   assign out_active = PB_FUNC_GPIO & port_b_direction_reg;

   // Live pin level, forced high under converter sampling
   assign pf_view = pf_sync | ADC_SAMPLING;

   // Pins have no reset: they always follow the outside level
   always @(posedge CORE_CLK) begin
      pb_meta <= PB_PIN_IN;
      pb_sync <= pb_meta;
      pf_meta <= PF_PIN_IN;
      pf_sync <= pf_meta;
   end

   // Register values widened to 16 bits for merging and reading
   always @* begin
      pb_data16 = 16'h0000;
      pb_dir16  = 16'h0000;
      pb_view16 = 16'h0000;
      pb_data16[PB_PINS-1:0] = port_b_data_reg;
      pb_dir16[PB_PINS-1:0]  = port_b_direction_reg;
      pb_view   = (port_b_data_reg & out_active) | (pb_sync & ~out_active);
      pb_view16[PB_PINS-1:0] = pb_view;
   end

   // Write path, completed in the data phase
   always @* begin
      next_a     = port_a_low_data_reg;
      next_b16   = pb_data16;
      next_c     = port_c_data_reg;
      next_d     = port_d_low_data_reg;
      next_e     = port_e_data_reg;
      next_dir16 = pb_dir16;
      if (wr_pend) begin
         case (wr_addr)
            `PIO_PA_DATA_OFS: begin
               next_a = merge16(port_a_low_data_reg, HWDATA, wr_be);
            end
            `PIO_PB_DATA_OFS: begin
               next_b16 = merge16(pb_data16, HWDATA, wr_be);
            end
            `PIO_PC_DATA_OFS: begin
               next_c = merge16(port_c_data_reg, HWDATA, wr_be);
            end
            `PIO_PD_DATA_OFS: begin
               next_d = merge16(port_d_low_data_reg, HWDATA, wr_be);
            end
            `PIO_PE_DATA_OFS: begin
               next_e = merge16(port_e_data_reg, HWDATA, wr_be);
            end
            `PIO_PB_DIR_OFS: begin
               next_dir16 = merge16(pb_dir16, HWDATA, wr_be);
            end
            default: begin
               // Port F and unmapped words: write dropped
               next_a = port_a_low_data_reg;
            end
         endcase
      end
      next_b   = next_b16[PB_PINS-1:0];
      next_dir = next_dir16[PB_PINS-1:0];
   end

   // Read path; uses next values so a read right after a write sees it, except port B data, which reads the current pin view
   always @* begin
      next_rdata = HRDATA;
      if (addr_phase && !HWRITE) begin
         case (HADDR[`PIO_ADDR_MSB:0])
            `PIO_PA_DATA_OFS: begin
               next_rdata = widen16(next_a);
            end
            `PIO_PB_DATA_OFS: begin
               next_rdata = widen16(pb_view16);
            end
            `PIO_PC_DATA_OFS: begin
               next_rdata = widen16(next_c);
            end
            `PIO_PD_DATA_OFS: begin
               next_rdata = widen16(next_d);
            end
            `PIO_PE_DATA_OFS: begin
               next_rdata = widen16(next_e);
            end
            `PIO_PB_DIR_OFS: begin
               next_rdata = widen16(next_dir16);
            end
            `PIO_PF_STATE_OFS: begin
               next_rdata = {24'h000000, pf_view};
            end
            default: begin
               next_rdata = 32'h00000000;
            end
         endcase
      end
   end

   // Bus slave state; the watchdog reset drops a pending write and clears HRDATA
   always @(posedge CORE_CLK or negedge RST_B) begin
      if (!RST_B) begin
         wr_pend   <= 1'b0;
         wr_addr   <= {(`PIO_ADDR_MSB+1){1'b0}};
         wr_be     <= 4'h0;
         HREADYOUT <= 1'b1;
         HRDATA    <= 32'h00000000;
         HRESP     <= `PIO_HRESP_OKAY;
      end else if (WATCHDOG_RST) begin
         wr_pend   <= 1'b0;
         HRDATA    <= 32'h00000000;
      end else begin
         wr_pend   <= addr_phase & HWRITE;
         if (addr_phase) begin
            wr_addr <= HADDR[`PIO_ADDR_MSB:0];
            wr_be   <= lanes(HSIZE, HADDR[1:0]);
         end
         HRDATA    <= next_rdata;
         HREADYOUT <= 1'b1;
         HRESP     <= `PIO_HRESP_OKAY;
      end
   end

   // Data and direction storage: cleared by power-on reset only
   always @(posedge CORE_CLK or negedge RST_B) begin
      if (!RST_B) begin
         port_a_low_data_reg  <= `PIO_DATA_RST;
         port_b_data_reg      <= {PB_PINS{1'b0}};
         port_c_data_reg      <= `PIO_DATA_RST;
         port_d_low_data_reg  <= `PIO_DATA_RST;
         port_e_data_reg      <= `PIO_DATA_RST;
         port_b_direction_reg <= {PB_PINS{1'b0}};
      end else if (!WATCHDOG_RST) begin
         port_a_low_data_reg  <= next_a;
         port_b_data_reg      <= next_b;
         port_c_data_reg      <= next_c;
         port_d_low_data_reg  <= next_d;
         port_e_data_reg      <= next_e;
         port_b_direction_reg <= next_dir;
      end else begin
         port_a_low_data_reg  <= port_a_low_data_reg;
         port_b_data_reg      <= port_b_data_reg;
         port_c_data_reg      <= port_c_data_reg;
         port_d_low_data_reg  <= port_d_low_data_reg;
         port_e_data_reg      <= port_e_data_reg;
         port_b_direction_reg <= port_b_direction_reg;
      end
   end

   // Pin drivers and data outputs
   always @(posedge CORE_CLK or negedge RST_B) begin
      if (!RST_B) begin
         PB_PIN_OUT <= {PB_PINS{1'b0}};
         PB_PIN_OE  <= {PB_PINS{1'b0}};
         PA_DATA    <= `PIO_DATA_RST;
         PC_DATA    <= `PIO_DATA_RST;
         PD_DATA    <= `PIO_DATA_RST;
         PE_DATA    <= `PIO_DATA_RST;
      end else begin
         PB_PIN_OUT <= port_b_data_reg;
         PB_PIN_OE  <= out_active;
         PA_DATA    <= port_a_low_data_reg;
         PC_DATA    <= port_c_data_reg;
         PD_DATA    <= port_d_low_data_reg;
         PE_DATA    <= port_e_data_reg;
      end
   end

endmodule // port_io_regs

`default_nettype wire

//--- verification/port_io_monitor.sv
// Port register block checks on the top module's ports.
// Assumes HREADY tied to HREADYOUT and word transfers only.
`timescale 1ns/10ps
`default_nettype none
`include "port_io_map.vh"
module port_io_monitor #(
   parameter PB_PINS = 10
) (
   input wire logic               CORE_CLK,
   input wire logic               RST_B,
   input wire logic               WATCHDOG_RST,
   input wire logic               HSEL,
   input wire logic [31:0]        HADDR,
   input wire logic [1:0]         HTRANS,
   input wire logic               HWRITE,
   input wire logic [31:0]        HWDATA,
   input wire logic               HREADYOUT,
   input wire logic [31:0]        HRDATA,
   input wire logic               HRESP,
   input wire logic [PB_PINS-1:0] PB_FUNC_GPIO,
   input wire logic [PB_PINS-1:0] PB_PIN_OUT,
   input wire logic [PB_PINS-1:0] PB_PIN_OE,
   input wire logic [15:0]        PA_DATA,
   input wire logic [7:0]         PF_PIN_IN,
   input wire logic [7:0]         ADC_SAMPLING
);
   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (!RST_B);
   wire logic tk = HSEL && HTRANS[1] && HREADYOUT && !WATCHDOG_RST;
   wire logic [7:0] a = HADDR[7:0];
   bus_okay_a:
      assert property (HREADYOUT && !HRESP) else $error("bus reply");
   pf_read_a:
      assert property (tk && !HWRITE && a == `PIO_PF_STATE_OFS |=>
         HRDATA == {24'h0, $past(PF_PIN_IN, 3) | $past(ADC_SAMPLING)})
      else $error("port F read");
   dir_oe_a:
      assert property (tk && HWRITE && a == `PIO_PB_DIR_OFS ##1 !WATCHDOG_RST
         |=> ##1 PB_PIN_OE == ($past(HWDATA[PB_PINS-1:0], 2)
         & $past(PB_FUNC_GPIO))) else $error("direction");
   gpio_only_a:
      assert property ((PB_PIN_OE & ~$past(PB_FUNC_GPIO)) == '0)
      else $error("enable outside gpio");
   pb_out_a:
      assert property (tk && HWRITE && a == `PIO_PB_DATA_OFS ##1 !WATCHDOG_RST
         |=> ##1 PB_PIN_OUT == $past(HWDATA[PB_PINS-1:0], 2))
      else $error("pin out");
   por_clear_a:
      assert property ($rose(RST_B) |-> PA_DATA == 16'h0000 &&
         PB_PIN_OUT == '0 && PB_PIN_OE == '0) else $error("reset value");
   wdt_keep_a:
      assert property (WATCHDOG_RST |=> ##1 $stable({PA_DATA, PB_PIN_OUT}))
      else $error("watchdog changed data");
   rd_upper_a:
      assert property (HRDATA[31:16] == 16'h0000) else $error("upper lanes");
endmodule // port_io_monitor
bind port_io_regs port_io_monitor #(.PB_PINS(PB_PINS)) u_mon (
   .CORE_CLK(CORE_CLK), .RST_B(RST_B), .WATCHDOG_RST(WATCHDOG_RST),
   .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE),
   .HWDATA(HWDATA), .HREADYOUT(HREADYOUT), .HRDATA(HRDATA),
   .HRESP(HRESP), .PB_FUNC_GPIO(PB_FUNC_GPIO), .PB_PIN_OUT(PB_PIN_OUT),
   .PB_PIN_OE(PB_PIN_OE), .PA_DATA(PA_DATA), .PF_PIN_IN(PF_PIN_IN),
   .ADC_SAMPLING(ADC_SAMPLING));
`default_nettype wire

//--- verification/port_pin_model.sv
// Outside of the port pins: other drivers and the converter.
// Assumes the bench sets the outside levels.
`timescale 1ns/10ps
`default_nettype none
module port_pin_model #(
   parameter PB_PINS = 10
) (
   input  wire logic [PB_PINS-1:0] pb_out,
   input  wire logic [PB_PINS-1:0] pb_oe,
   input  wire logic [PB_PINS-1:0] pb_ext,
   input  wire logic [7:0]         pf_ext,
   input  wire logic [7:0]         conv,
   output logic      [PB_PINS-1:0] pb_pin,
   output logic      [7:0]         pf_pin,
   output logic      [7:0]         sampling
);
   // Device wins where it drives
   assign pb_pin = (pb_oe & pb_out) | (~pb_oe & pb_ext);
   assign pf_pin = pf_ext;
   assign sampling = conv;
endmodule // port_pin_model
`default_nettype wire

//--- verification/tb_top.sv
// Bus-level tests of the port register block.
// Assumes zero-wait AHB-Lite slave and the pin model.
`timescale 1ns/10ps
`default_nettype none
`include "port_io_map.vh"
module tb_top;
   localparam int PB_PINS = 10;
   logic CORE_CLK, RST_B, WATCHDOG_RST, HSEL, HWRITE;
   logic [31:0] HADDR, HWDATA, r;
   logic [1:0] HTRANS;
   logic [2:0] HSIZE;
   logic [PB_PINS-1:0] PB_FUNC_GPIO, pb_ext;
   logic [7:0] pf_ext, conv;
   wire logic HREADYOUT, HRESP;
   wire logic [31:0] HRDATA;
   wire logic [PB_PINS-1:0] PB_PIN_IN, PB_PIN_OUT, PB_PIN_OE;
   wire logic [15:0] PA_DATA, PC_DATA, PD_DATA, PE_DATA;
   wire logic [7:0] PF_PIN_IN, ADC_SAMPLING;
   int mismatches, check_count;
   port_io_regs #(.PB_PINS(PB_PINS)) u_dut (
      .CORE_CLK(CORE_CLK), .RST_B(RST_B), .WATCHDOG_RST(WATCHDOG_RST),
      .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE),
      .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT),
      .HREADYOUT(HREADYOUT), .HRDATA(HRDATA), .HRESP(HRESP),
      .PB_FUNC_GPIO(PB_FUNC_GPIO), .PB_PIN_IN(PB_PIN_IN),
      .PB_PIN_OUT(PB_PIN_OUT), .PB_PIN_OE(PB_PIN_OE), .PA_DATA(PA_DATA),
      .PC_DATA(PC_DATA), .PD_DATA(PD_DATA), .PE_DATA(PE_DATA),
      .PF_PIN_IN(PF_PIN_IN), .ADC_SAMPLING(ADC_SAMPLING));
   port_pin_model #(.PB_PINS(PB_PINS)) u_pins (.pb_out(PB_PIN_OUT),
      .pb_oe(PB_PIN_OE), .pb_ext(pb_ext), .pf_ext(pf_ext), .conv(conv),
      .pb_pin(PB_PIN_IN), .pf_pin(PF_PIN_IN), .sampling(ADC_SAMPLING));
   initial begin
      CORE_CLK = 1'b0;
      forever #5 CORE_CLK = ~CORE_CLK;
   end
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      check_count++;
      if (g !== e) begin
         mismatches++;
         $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic xfer(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
      HSEL <= 1'b1;
      HTRANS <= `PIO_HTRANS_NONSEQ;
      HWRITE <= w;
      HADDR <= {24'h0, a};
      do @(posedge CORE_CLK); while (HREADYOUT !== 1'b1);
      HSEL <= 1'b0;
      HTRANS <= 2'h0;
      HWDATA <= d;
      do @(posedge CORE_CLK); while (HREADYOUT !== 1'b1);
      r = HRDATA;
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] e);
      xfer(1'b0, a, 32'h0);
      chk(r, e);
   endtask
   // Reads ports A to E data and the direction register, then the data outputs, not PB_PIN_OE
   task automatic sweep(input logic z);
      for (int i = 0; i < 6; i++)
         rc(8'(4 * i), i == 1 ? 32'h2aa : z ? 32'h0 : (32'ha5c0 + 32'(i))
            & (i == 5 ? 32'h3ff : 32'hffff));
      @(negedge CORE_CLK);
      chk(32'(PA_DATA), z ? 32'h0 : 32'ha5c0);
      chk(32'(PB_PIN_OUT), z ? 32'h0 : 32'h1c1);
      chk(32'(PC_DATA), z ? 32'h0 : 32'ha5c2);
      chk(32'(PD_DATA), z ? 32'h0 : 32'ha5c3);
      chk(32'(PE_DATA), z ? 32'h0 : 32'ha5c4);
      @(posedge CORE_CLK);
   endtask
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   initial begin
      #100000;
      mismatches++;
      end_of_test;
   end
   initial begin
      {RST_B, WATCHDOG_RST, HSEL, HWRITE, HADDR, HWDATA, HTRANS} = '0;
      HSIZE = 3'h2;
      PB_FUNC_GPIO = '0;
      pb_ext = 10'h2aa;
      pf_ext = 8'h3c;
      conv = 8'h00;
      repeat (16) @(posedge CORE_CLK);
      RST_B <= 1'b1;
      @(posedge CORE_CLK);
      sweep(1'b1);
      for (int i = 0; i < 6; i++)
         xfer(1'b1, 8'(4 * i), 32'hffff_a5c0 + 32'(i));
      sweep(1'b0);
      $display("test registers done");
      WATCHDOG_RST <= 1'b1;
      xfer(1'b1, `PIO_PA_DATA_OFS, 32'h0000_1234);
      WATCHDOG_RST <= 1'b0;
      @(posedge CORE_CLK);
      sweep(1'b0);
      RST_B <= 1'b0;
      repeat (2) @(posedge CORE_CLK);
      RST_B <= 1'b1;
      @(posedge CORE_CLK);
      sweep(1'b1);
      $display("test resets done");
      PB_FUNC_GPIO <= 10'h3ff;
      xfer(1'b1, `PIO_PB_DIR_OFS, 32'h2a5);
      xfer(1'b1, `PIO_PB_DATA_OFS, 32'h15a);
      repeat (3) @(posedge CORE_CLK);
      @(negedge CORE_CLK);
      chk(32'(PB_PIN_OE), 32'h2a5);
      chk(32'(PB_PIN_OUT), 32'h15a);
      @(posedge CORE_CLK);
      PB_FUNC_GPIO <= 10'h0f0;
      repeat (3) @(posedge CORE_CLK);
      @(negedge CORE_CLK);
      chk(32'(PB_PIN_OE), 32'h0a0);
      @(posedge CORE_CLK);
      rc(`PIO_PB_DATA_OFS, 32'h20a);
      $display("test port B pins done");
      rc(`PIO_PF_STATE_OFS, 32'h3c);
      conv <= 8'h81;
      rc(`PIO_PF_STATE_OFS, 32'hbd);
      conv <= 8'h00;
      xfer(1'b1, `PIO_PF_STATE_OFS, 32'hc3);
      rc(`PIO_PF_STATE_OFS, 32'h3c);
      pf_ext <= 8'h96;
      repeat (3) @(posedge CORE_CLK);
      rc(`PIO_PF_STATE_OFS, 32'h96);
      rc(8'h1c, 32'h0);
      $display("test port F done");
      end_of_test;
   end
endmodule // tb_top
`default_nettype wire
